// [rtl/sms_defines.svh]
// constants for the sync-mode and supervisor controller
// assumes a 20 MHz reference clock; included by bare name
// How it works
// - strap the frequency pin once at power-up, then float it
// - 250 kHz and 500 kHz codes need no strap resistor
// - mode strap picks quiet/economy and threshold; defaults give 93%
// - supervisor threshold is one of 80, 87, 93 or 96 percent
// - power-good is pulled low while output is out of regulation
// - power-good releases only when the delay ramp reaches its end
// - sync line is two-way: drive it or detect another driver
// - default role is master, driving the line at strapped frequency
// - slaves switch in phase with the line, opposite to the master
// - with an external reference all devices switch in phase with it
// - ten consecutive fast line periods put the device into slave
// - in slave the oscillator runs at 250 kHz nominal
// - slower than 275 kHz: drive one 250 kHz pulse, then become master unless latched
// - line low at power-up latches slave mode until next lockout
// - slope compensation follows the frequency strap, frozen at power-up
`ifndef SMS_DEFINES_SVH
`define SMS_DEFINES_SVH

`define SMS_CLK_HZ        20000000
`define SMS_F250_HZ       250000
`define SMS_F500_HZ       500000
`define SMS_F1M_HZ        1000000
`define SMS_F2M_HZ        2000000
`define SMS_P250          (`SMS_CLK_HZ / `SMS_F250_HZ)
`define SMS_P500          (`SMS_CLK_HZ / `SMS_F500_HZ)
`define SMS_P1M           (`SMS_CLK_HZ / `SMS_F1M_HZ)
`define SMS_P2M           (`SMS_CLK_HZ / `SMS_F2M_HZ)
`define SMS_SLOW_HZ       275000
`define SMS_SLOW_CYC      (`SMS_CLK_HZ / `SMS_SLOW_HZ)
`define SMS_SPREAD_PCT    10
`define SMS_ENTRY_PERIODS 10
`define SMS_PULSE_NS      100
`define SMS_PULSE_CYC     ((`SMS_PULSE_NS * (`SMS_CLK_HZ / 1000000) + 999) / 1000)
`define SMS_STRAP_CYC     8
`define SMS_DLY_RESET     16'h0FA0

`define SMS_REG_STATUS    4'h0
`define SMS_REG_DELAY     4'h4
`define SMS_ST_RUN        0
`define SMS_ST_SLAVE      1
`define SMS_ST_LATCHED    2
`define SMS_ST_PGOOD      3
`define SMS_ST_ECON       4
`define SMS_ST_THR_LO     5
`define SMS_ST_FSW_LO     8
`define SMS_RESP_OKAY     2'b00
`define SMS_RESP_SLVERR   2'b10

`endif

// [rtl/sms_pkg.sv]
// types for the sync-mode and supervisor controller
// no assumptions beyond a SystemVerilog tool
package sms_pkg;
  typedef enum logic [1:0] {
    SMS_PWR_STRAP = 2'b01,
    SMS_PWR_RUN   = 2'b10
  } sms_pwr_t;

  typedef enum logic [2:0] {
    SMS_ROLE_MASTER = 3'b001,
    SMS_ROLE_SLAVE  = 3'b010,
    SMS_ROLE_EXIT   = 3'b100
  } sms_role_t;

  typedef enum logic [1:0] {
    SMS_FSW_250 = 2'h0,
    SMS_FSW_500 = 2'h1,
    SMS_FSW_1M  = 2'h2,
    SMS_FSW_2M  = 2'h3
  } sms_fsw_t;

  typedef enum logic [1:0] {
    SMS_THR_93 = 2'h0,
    SMS_THR_80 = 2'h1,
    SMS_THR_87 = 2'h2,
    SMS_THR_96 = 2'h3
  } sms_thr_t;
endpackage

// [rtl/sms_in_sync.sv]
// three-flop input synchroniser with agreement filter
// inputs come from outside the ref_clk_in domain
`timescale 1ns/1ps
module sms_in_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             nrst_in,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic ff1;
      logic ff2;
      logic ff3;
      always_ff @(posedge ref_clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          ff1          <= 1'b0;
          ff2          <= 1'b0;
          ff3          <= 1'b0;
          level_out[i] <= 1'b0;
        end
        else
        begin
          ff1 <= async_in[i];
          ff2 <= ff1;
          ff3 <= ff2;
          // change counts once stages two and three agree
          if (ff2 == ff3)
            level_out[i] <= ff3;
        end
      end
    end
  endgenerate
endmodule

// [rtl/sms_sync_ctrl.sv]
// sync-line role control, strap capture and output supervisor
// assumes a 20 MHz ref_clk_in and an AXI4-Lite master on the same clock
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "sms_defines.svh"
module sms_sync_ctrl #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              nrst_in,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // frequency strap pin
  input  wire logic [1:0]        freq_strap_pin_in,
  output logic                   freq_strap_pin_out,
  output logic                   freq_strap_pin_oe_n_out,
  // mode/threshold strap pin: bit 2 economy, bits 1:0 threshold
  input  wire logic [2:0]        mode_threshold_strap_pin_in,
  // shared phase line
  input  wire logic              shared_phase_line_in,
  output logic                   shared_phase_line_out,
  output logic                   shared_phase_line_oe_n_out,
  // regulator side
  input  wire logic              reg_in_regulation_in,
  output logic                   soft_start_en_out,
  output logic                   switch_pulse_out,
  output logic [1:0]             osc_sel_out,
  output logic [1:0]             slope_sel_out,
  output logic [1:0]             threshold_sel_out,
  output logic                   quiet_mode_out,
  output logic                   economy_mode_out,
  output logic                   power_good_oe_n_out
);
  localparam logic [7:0] P250     = 8'(`SMS_P250);
  localparam logic [7:0] P500     = 8'(`SMS_P500);
  localparam logic [7:0] P1M      = 8'(`SMS_P1M);
  localparam logic [7:0] P2M      = 8'(`SMS_P2M);
  localparam logic [7:0] SLOW_CYC = 8'(`SMS_SLOW_CYC);
  localparam logic [7:0] PULSE    = 8'(`SMS_PULSE_CYC);
  localparam logic [3:0] ENTRY_M1 = 4'(`SMS_ENTRY_PERIODS - 1);
  localparam logic [3:0] STRAP_M1 = 4'(`SMS_STRAP_CYC - 1);

  // synchronised pins
  logic [6:0] pins_s;
  sms_in_sync #(.WIDTH(7)) u_in_sync (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .async_in   ({reg_in_regulation_in, shared_phase_line_in, mode_threshold_strap_pin_in, freq_strap_pin_in}),
    .level_out  (pins_s)
  );
  wire       ok_s     = pins_s[6];
  wire       line_s   = pins_s[5];
  wire [2:0] mode_s   = pins_s[4:2];
  wire [1:0] fstrap_s = pins_s[1:0];

  sms_pkg::sms_pwr_t  pwr;
  sms_pkg::sms_role_t role;
  sms_pkg::sms_role_t next_role;
  logic [3:0]  strap_cnt;
  sms_pkg::sms_fsw_t  freq_strap_pin;
  logic [2:0]  mode;
  logic        latched;
  logic        line_q;
  logic [7:0]  per_cnt;
  logic [3:0]  fast_cnt;
  logic [7:0]  osc_cnt;
  logic [15:0] dly_cnt;
  logic [15:0] dly_reg;

  // power-up strap phase
  wire pwr_run   = (pwr == sms_pkg::SMS_PWR_RUN);
  wire strap_end = (pwr == sms_pkg::SMS_PWR_STRAP) && (strap_cnt == STRAP_M1);
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pwr       <= sms_pkg::SMS_PWR_STRAP;
      strap_cnt <= 4'h0;
      freq_strap_pin       <= sms_pkg::SMS_FSW_250;
      mode      <= 3'h0;
      latched   <= 1'b0;
    end
    else if (strap_end)
    begin
      pwr     <= sms_pkg::SMS_PWR_RUN;
      freq_strap_pin     <= sms_pkg::sms_fsw_t'(fstrap_s);
      mode    <= mode_s;
      latched <= ~line_s;
    end
    else if (!pwr_run)
      strap_cnt <= strap_cnt + 4'h1;
  end

  // oscillator period selection
  wire [7:0] strap_period = (freq_strap_pin == sms_pkg::SMS_FSW_250) ? P250 :
                            (freq_strap_pin == sms_pkg::SMS_FSW_500) ? P500 :
                            (freq_strap_pin == sms_pkg::SMS_FSW_1M)  ? P1M  : P2M;
  wire       use_250      = latched || (role != sms_pkg::SMS_ROLE_MASTER);
  wire [7:0] cur_period   = use_250 ? P250 : strap_period;
  wire [7:0] fast_limit   = 8'((16'(strap_period) * 16'd100) / 16'(100 + `SMS_SPREAD_PCT));

  // line edge timing
  wire line_edge = pwr_run && line_s && !line_q;
  wire is_fast   = (per_cnt < fast_limit);
  wire slow_to   = (per_cnt == SLOW_CYC);
  wire entry_hit = line_edge && is_fast && (fast_cnt == ENTRY_M1);
  wire osc_wrap  = (osc_cnt == cur_period - 8'h01);

  always_comb
  begin
    next_role = role;
    unique case (role)
      sms_pkg::SMS_ROLE_MASTER:
        if (strap_end && ~line_s)
          next_role = sms_pkg::SMS_ROLE_SLAVE;
        else if (pwr_run && entry_hit)
          next_role = sms_pkg::SMS_ROLE_SLAVE;
      sms_pkg::SMS_ROLE_SLAVE:
        if (slow_to)
          next_role = sms_pkg::SMS_ROLE_EXIT;
      sms_pkg::SMS_ROLE_EXIT:
        if (osc_wrap)
          next_role = latched ? sms_pkg::SMS_ROLE_SLAVE : sms_pkg::SMS_ROLE_MASTER;
    endcase
  end

  wire in_slave = (role == sms_pkg::SMS_ROLE_SLAVE);
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      role     <= sms_pkg::SMS_ROLE_MASTER;
      line_q   <= 1'b0;
      per_cnt  <= 8'h00;
      fast_cnt <= 4'h0;
      osc_cnt  <= 8'h00;
    end
    else
    begin
      role    <= next_role;
      line_q  <= line_s;
      per_cnt <= line_edge ? 8'h00 : (per_cnt == 8'hFF ? per_cnt : per_cnt + 8'h01);
      if (line_edge && is_fast && !in_slave)
        fast_cnt <= fast_cnt + 4'h1;
      else if (line_edge || in_slave)
        fast_cnt <= 4'h0;
      if ((in_slave && (line_edge || slow_to)) || osc_wrap)
        osc_cnt <= 8'h00;
      else
        osc_cnt <= osc_cnt + 8'h01;
    end
  end

  // line drive and switching phase
  wire drive_line = pwr_run && !in_slave;
  wire sw_now     = pwr_run && (in_slave ? line_edge : (osc_cnt == (cur_period >> 1)));
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      shared_phase_line_out      <= 1'b0;
      shared_phase_line_oe_n_out <= 1'b1;
      switch_pulse_out           <= 1'b0;
    end
    else
    begin
      shared_phase_line_out      <= drive_line && (osc_cnt < PULSE);
      shared_phase_line_oe_n_out <= ~drive_line;
      switch_pulse_out           <= sw_now;
    end
  end

  // supervisor delay
  wire pgood = ok_s && (dly_cnt == dly_reg);
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      dly_cnt <= 16'h0000;
    else if (!ok_s)
      dly_cnt <= 16'h0000;
    else if (dly_cnt != dly_reg)
      dly_cnt <= dly_cnt + 16'h0001;
  end

  // strap-derived outputs
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      freq_strap_pin_out      <= 1'b0;
      freq_strap_pin_oe_n_out <= 1'b0;
      soft_start_en_out       <= 1'b0;
      osc_sel_out             <= 2'h0;
      slope_sel_out           <= 2'h0;
      threshold_sel_out       <= 2'h0;
      quiet_mode_out          <= 1'b0;
      economy_mode_out        <= 1'b0;
      power_good_oe_n_out     <= 1'b0;
    end
    else
    begin
      freq_strap_pin_oe_n_out <= pwr_run;
      soft_start_en_out       <= pwr_run;
      osc_sel_out             <= use_250 ? sms_pkg::SMS_FSW_250 : freq_strap_pin;
      slope_sel_out           <= freq_strap_pin;
      threshold_sel_out       <= mode[1:0];
      quiet_mode_out          <= pwr_run && !mode[2];
      economy_mode_out        <= pwr_run && mode[2];
      power_good_oe_n_out     <= pwr_run && pgood;
    end
  end

  // axi4-lite slave
  logic              aw_got;
  logic              w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  wire         aw_hs    = s_axi_awvalid_in && s_axi_awready_out;
  wire         w_hs     = s_axi_wvalid_in && s_axi_wready_out;
  wire         ar_hs    = s_axi_arvalid_in && s_axi_arready_out;
  wire         aw_have  = aw_got || aw_hs;
  wire         w_have   = w_got || w_hs;
  wire         wr_go    = aw_have && w_have && !s_axi_bvalid_out;
  wire [ADDR_W-1:0] wa  = aw_got ? aw_addr : s_axi_awaddr_in;
  wire [31:0]  wd       = w_got ? w_data : s_axi_wdata_in;
  wire [3:0]   ws       = w_got ? w_strb : s_axi_wstrb_in;
  wire         wr_dly   = wr_go && (wa == ADDR_W'(`SMS_REG_DELAY));
  wire         wr_ok    = wr_dly || (wa == ADDR_W'(`SMS_REG_STATUS));
  wire         next_bv  = wr_go || (s_axi_bvalid_out && !s_axi_bready_in);
  wire         next_awg = aw_have && !wr_go;
  wire         next_wg  = w_have && !wr_go;
  wire         next_rv  = ar_hs || (s_axi_rvalid_out && !s_axi_rready_in);
  wire         rd_st    = (s_axi_araddr_in == ADDR_W'(`SMS_REG_STATUS));
  wire         rd_dl    = (s_axi_araddr_in == ADDR_W'(`SMS_REG_DELAY));
  logic [31:0] status;
  always_comb
  begin
    status = 32'h0000_0000;
    status[`SMS_ST_RUN]                    = pwr_run;
    status[`SMS_ST_SLAVE]                  = !(role == sms_pkg::SMS_ROLE_MASTER);
    status[`SMS_ST_LATCHED]                = latched;
    status[`SMS_ST_PGOOD]                  = pgood;
    status[`SMS_ST_ECON]                   = mode[2];
    status[`SMS_ST_THR_LO+1:`SMS_ST_THR_LO] = mode[1:0];
    status[`SMS_ST_FSW_LO+1:`SMS_ST_FSW_LO] = freq_strap_pin;
  end
  wire [31:0] rdata = rd_st ? status : (rd_dl ? {16'h0000, dly_reg} : 32'h0000_0000);

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      aw_got            <= 1'b0;
      w_got             <= 1'b0;
      aw_addr           <= '0;
      w_data            <= 32'h0000_0000;
      w_strb            <= 4'h0;
      dly_reg           <= `SMS_DLY_RESET;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `SMS_RESP_OKAY;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= `SMS_RESP_OKAY;
    end
    else
    begin
      aw_got            <= next_awg;
      w_got             <= next_wg;
      s_axi_awready_out <= !next_awg && !next_bv;
      s_axi_wready_out  <= !next_wg && !next_bv;
      s_axi_bvalid_out  <= next_bv;
      s_axi_arready_out <= !next_rv;
      s_axi_rvalid_out  <= next_rv;
      if (aw_hs)
        aw_addr <= s_axi_awaddr_in;
      if (w_hs)
      begin
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (wr_go)
        s_axi_bresp_out <= wr_ok ? `SMS_RESP_OKAY : `SMS_RESP_SLVERR;
      if (wr_dly && ws[0])
        dly_reg[7:0] <= wd[7:0];
      if (wr_dly && ws[1])
        dly_reg[15:8] <= wd[15:8];
      if (ar_hs)
      begin
        s_axi_rdata_out <= rdata;
        s_axi_rresp_out <= (rd_st || rd_dl) ? `SMS_RESP_OKAY : `SMS_RESP_SLVERR;
      end
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  chk_strap_floats: assert property (pwr_run |=> freq_strap_pin_oe_n_out)
    else $error("frequency strap pin driven after strap phase");
  chk_latched_osc: assert property (latched |-> use_250 && cur_period == P250)
    else $error("latched slave not at 250 kHz");
  chk_pg_low: assert property (!ok_s |=> ##1 !power_good_oe_n_out)
    else $error("power good released out of regulation");
  chk_pg_delay: assert property ($rose(power_good_oe_n_out) |-> $past(ok_s) && $past(dly_cnt) == $past(dly_reg))
    else $error("power good released before delay end");
  chk_slave_entry: assert property (role == sms_pkg::SMS_ROLE_MASTER && pwr_run && next_role == sms_pkg::SMS_ROLE_SLAVE
                                    |-> fast_cnt == ENTRY_M1 && line_edge)
    else $error("slave entered without ten fast periods");
  chk_slave_phase: assert property (in_slave && pwr_run && line_edge |=> switch_pulse_out)
    else $error("slave switching not aligned to line");
  chk_exit_master: assert property (role == sms_pkg::SMS_ROLE_EXIT && osc_wrap |=>
                                    (role == sms_pkg::SMS_ROLE_MASTER) == !latched)
    else $error("wrong role after exit pulse");
  chk_slope_hold: assert property (pwr_run ##1 pwr_run ##1 pwr_run |-> $stable(slope_sel_out))
    else $error("slope setting changed during operation");
  chk_fast_clear: assert property (line_edge && !is_fast |=> fast_cnt == 4'h0)
    else $error("slow period did not clear count");
  chk_dly_restart: assert property (ok_s ##1 !ok_s |=> dly_cnt == 16'h0000)
    else $error("delay counter not cleared on regulation loss");

  cov_enter_slave: cover property (role == sms_pkg::SMS_ROLE_MASTER ##1 role == sms_pkg::SMS_ROLE_SLAVE);
  cov_back_master: cover property (role == sms_pkg::SMS_ROLE_EXIT ##1 role == sms_pkg::SMS_ROLE_MASTER);
  cov_pg_release: cover property ($rose(power_good_oe_n_out));
  cov_latched: cover property (pwr_run && latched);
endmodule

// [tb/sms_line_partner.sv]
// external clock source on the shared phase line
// clock runs only while run_in is high; released line floats to its pull-up
`timescale 1ns/1ps
module sms_line_partner #(
  parameter int HALF_NS = 200
) (
  // control
  input  wire logic run_in,
  input  wire logic hold_low_in,
  // line
  output logic      drive_out,
  output logic      drive_en_out
);
  logic phase;

  initial phase = 1'b0;
  always #(HALF_NS) phase = run_in ? ~phase : 1'b0;
  assign drive_en_out = run_in | hold_low_in;
  assign drive_out    = run_in & phase;
endmodule

// [tb/tb_sync_mode_and_supervisor_ctrl.sv]
// bench for the sync-mode and supervisor controller
// partner on the shared line wins over the device; idle line pulled high
`timescale 1ns/1ps
`include "sms_defines.svh"
module tb_sync_mode_and_supervisor_ctrl;
  logic        ref_clk_in;
  logic        nrst_in;
  logic [3:0]  awaddr;
  logic [3:0]  araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [1:0]  freq_strap_pin, osc_sel, slope_sel, thr_sel;
  logic [2:0]  mts;
  logic        line, dev_line, dev_oe_n, p_val, p_en, p_run, p_hold;
  logic        reg_ok, sw_pulse, pg_oe_n, ss_en, fs_oe_n, fs_out, quiet, econ, prev;
  int          bad_count, cmp_count, cyc, sw_at, per;

  sms_line_partner partner (.run_in(p_run), .hold_low_in(p_hold), .drive_out(p_val), .drive_en_out(p_en));
  assign line = p_en ? p_val : (dev_oe_n ? 1'b1 : dev_line);

  sms_sync_ctrl uut (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .freq_strap_pin_in(freq_strap_pin), .freq_strap_pin_out(fs_out), .freq_strap_pin_oe_n_out(fs_oe_n),
    .mode_threshold_strap_pin_in(mts),
    .shared_phase_line_in(line), .shared_phase_line_out(dev_line), .shared_phase_line_oe_n_out(dev_oe_n),
    .reg_in_regulation_in(reg_ok), .soft_start_en_out(ss_en), .switch_pulse_out(sw_pulse),
    .osc_sel_out(osc_sel), .slope_sel_out(slope_sel), .threshold_sel_out(thr_sel),
    .quiet_mode_out(quiet), .economy_mode_out(econ), .power_good_oe_n_out(pg_oe_n)
  );

  initial ref_clk_in = 1'b0;
  always #25 ref_clk_in = ~ref_clk_in;

  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge ref_clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic probe(input int w);
    case (w)
      0: return dev_oe_n;
      1: return pg_oe_n;
      2: return line;
      default: return sw_pulse;
    endcase
  endfunction

  // waits a bounded time for a watched bit, then compares it
  task automatic wait_bit(input int w, input logic v, input int lim);
    for (int n = 0; n < lim && probe(w) !== v; n++) @(posedge ref_clk_in);
    check(32'(probe(w)), 32'(v));
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge ref_clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge ref_clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge ref_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge ref_clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic do_reset(input logic [1:0] f, input logic [2:0] m, input logic hold);
    nrst_in <= 1'b0;
    freq_strap_pin <= f;
    mts <= m;
    p_hold <= hold;
    repeat (8) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    check(32'(fs_oe_n), 32'h0);
    check(32'(fs_out), 32'h0);
    repeat (18) @(posedge ref_clk_in);
    p_hold <= 1'b0;
  endtask

  task automatic t_straps;
    for (int i = 0; i < 4; i++)
    begin
      do_reset(2'(i), {i[0], 2'(i)}, 1'b0);
      check(32'(fs_oe_n), 32'h1);
      check(32'(ss_en), 32'h1);
      check(32'(osc_sel), 32'(i));
      check(32'(slope_sel), 32'(i));
      check(32'(thr_sel), 32'(i));
      check(32'(econ), 32'(i[0]));
      check(32'(quiet), 32'(!i[0]));
      axi_read(`SMS_REG_STATUS, rd, rsp);
      check(rd, {22'h0, 2'(i), 1'b0, 2'(i), i[0], 4'h1});
    end
    do_reset(2'h1, 3'h0, 1'b0);
    freq_strap_pin <= 2'h3;
    repeat (20) @(posedge ref_clk_in);
    check(32'(slope_sel), 32'h1);
    check(32'(osc_sel), 32'h1);
    freq_strap_pin <= 2'h1;
  endtask

  task automatic t_regs;
    axi_read(`SMS_REG_DELAY, rd, rsp);
    check(rd, 32'h0FA0);
    axi_write(`SMS_REG_DELAY, 32'h0014, rsp);
    check(32'(rsp), 32'(`SMS_RESP_OKAY));
    axi_read(`SMS_REG_DELAY, rd, rsp);
    check(rd, 32'h0014);
    axi_write(4'h8, 32'h0001, rsp);
    check(32'(rsp), 32'(`SMS_RESP_SLVERR));
    axi_read(4'h8, rd, rsp);
    check({rd[29:0], rsp}, {30'h0, `SMS_RESP_SLVERR});
  endtask

  task automatic t_super;
    for (int k = 0; k < 2; k++)
    begin
      reg_ok <= 1'b1;
      repeat (20)
      begin
        @(posedge ref_clk_in);
        check(32'(pg_oe_n), 32'h0);
      end
      wait_bit(1, 1'b1, 8);
      reg_ok <= 1'b0;
      wait_bit(1, 1'b0, 8);
    end
  endtask

  task automatic t_master;
    check(32'(dev_oe_n), 32'h0);
    wait_bit(2, 1'b0, 100);
    wait_bit(2, 1'b1, 100);
    sw_at = 0;
    per = 0;
    prev = 1'b1;
    for (int k = 1; k <= 60 && per == 0; k++)
    begin
      @(posedge ref_clk_in);
      if (sw_pulse && sw_at == 0) sw_at = k;
      if (line && !prev) per = k;
      prev = line;
    end
    check(per, 40);
    check(32'(sw_at >= 19 && sw_at <= 21), 32'h1);
  endtask

  task automatic t_slave;
    p_run <= 1'b1;
    repeat (60) @(posedge ref_clk_in);
    check(32'(dev_oe_n), 32'h0);
    wait_bit(0, 1'b1, 120);
    check(32'(osc_sel), 32'h0);
    axi_read(`SMS_REG_STATUS, rd, rsp);
    check(32'(rd[1]), 32'h1);
    wait_bit(2, 1'b0, 10);
    wait_bit(2, 1'b1, 10);
    wait_bit(3, 1'b1, 8);
    repeat (200) @(posedge ref_clk_in);
    check(32'(dev_oe_n), 32'h1);
    p_run <= 1'b0;
    wait_bit(0, 1'b0, 150);
    check(32'(osc_sel), 32'h0);
    for (int n = 0; n < 200 && osc_sel !== 2'h1; n++) @(posedge ref_clk_in);
    check(32'(osc_sel), 32'h1);
  endtask

  task automatic t_latched;
    do_reset(2'h1, 3'h0, 1'b1);
    check(32'(osc_sel), 32'h0);
    check(32'(slope_sel), 32'h1);
    axi_read(`SMS_REG_STATUS, rd, rsp);
    check(32'(rd[2]), 32'h1);
    repeat (400) @(posedge ref_clk_in);
    check(32'(osc_sel), 32'h0);
  endtask

  initial
  begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    {reg_ok, p_run, p_hold, freq_strap_pin, mts} = '0;
    nrst_in = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    t_straps();
    t_regs();
    t_super();
    t_master();
    t_slave();
    t_latched();
    report_and_stop();
  end
endmodule
